/* File: core/bpf_pkg.sv */
// constants and types for the biosignal uart packet framer
// assumes one 100 MHz clock and a synchronous active-high reset
// Contract
// - header, payload, then checksum, sent as bytes
// - each byte: start, eight data, one stop
// - header is 0xaa 0xaa then length byte
// - length byte counts the payload bytes exactly
// - checksum is inverted low byte of sum
// - payload is back-to-back records, all consumed
// - leading 0x55 bytes give the extension level
// - code byte is never 0x55 or 0xaa
// - codes below 0x80 carry one data byte
// - codes from 0x80 carry a length byte
// - level 0 code 0x02 is signal quality
// - level 0 code 0x03 is heart rate
// - level 0 code 0x80, length 2, raw sample
package bpf_pkg;
    // framing byte values
    localparam logic [7:0] SYNC_BYTE           = 8'haa;
    localparam logic [7:0] EXTENSION_PREFIX_BYTE = 8'h55;
    localparam logic [7:0] PAYLOAD_BYTE_COUNT  = 8'h08;
    localparam logic [7:0] CODE_QUALITY        = 8'h02;
    localparam logic [7:0] CODE_HEART          = 8'h03;
    localparam logic [7:0] CODE_RAW            = 8'h80;
    localparam logic [7:0] RAW_LEN             = 8'h02;
    localparam logic [7:0] LONG_CODE_MIN       = 8'h80;
    // position of each byte inside the packet
    localparam logic [3:0] IDX_SYNC0 = 4'h0;
    localparam logic [3:0] IDX_SYNC1 = 4'h1;
    localparam logic [3:0] IDX_LEN   = 4'h2;
    localparam logic [3:0] IDX_QCODE = 4'h3;
    localparam logic [3:0] IDX_QDATA = 4'h4;
    localparam logic [3:0] IDX_HCODE = 4'h5;
    localparam logic [3:0] IDX_HDATA = 4'h6;
    localparam logic [3:0] IDX_RCODE = 4'h7;
    localparam logic [3:0] IDX_RLEN  = 4'h8;
    localparam logic [3:0] IDX_RHI   = 4'h9;
    localparam logic [3:0] IDX_RLO   = 4'ha;
    localparam logic [3:0] IDX_CKSUM = 4'hb;
    // serial timing: bit time rounded down to whole cycles
    localparam int CLK_HZ    = 100_000_000;
    localparam int BAUD_RATE = 57600;
    localparam logic [10:0] BIT_CYCLES = 11'(CLK_HZ / BAUD_RATE);
    localparam logic [3:0]  LAST_BIT   = 4'h9;
    localparam logic [1:0]  BUF_DEPTH  = 2'h2;

    typedef enum logic {PH_IDLE, PH_SEND} bpf_phase_t;

    typedef struct packed {
        bpf_phase_t  phase;
        logic [3:0]  idx;
        logic [7:0]  sum;
        logic [7:0]  quality;
        logic [7:0]  heart;
        logic [15:0] raw;
        logic        txBusy;
        logic [9:0]  shift;
        logic [3:0]  bitCnt;
        logic [10:0] baudCnt;
        logic        txd;
    } bpf_frm_state_t;

    typedef struct packed {
        logic [1:0][7:0] mem;
        logic            wrPtr;
        logic            rdPtr;
        logic [1:0]      count;
    } bpf_buf_state_t;
endpackage : bpf_pkg

/* File: core/bpf_byte_buf.sv */
// two-entry byte buffer with valid/ready on both sides
// assumes the filler and drainer share mclk with the buffer
`timescale 1ns/1ps
`default_nettype none
module bpf_byte_buf (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       inValid,
    output logic            inReady,
    input  wire logic [7:0] inData,
    output logic            outValid,
    input  wire logic       outReady,
    output logic [7:0]      outData
);
    import bpf_pkg::*;

    bpf_buf_state_t s_r;
    bpf_buf_state_t s_nxt;
    logic           push;
    logic           pop;

    // handshakes straight from the occupancy count
    assign inReady  = (s_r.count != BUF_DEPTH);
    assign outValid = (s_r.count != 2'h0);
    assign outData  = s_r.mem[s_r.rdPtr];
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;

    // next state: write, read and count update
    always_comb begin
        s_nxt = s_r;
        if (push) begin
            s_nxt.mem[s_r.wrPtr] = inData;
            s_nxt.wrPtr = ~s_r.wrPtr;
        end
        if (pop) begin
            s_nxt.rdPtr = ~s_r.rdPtr;
        end
        if (push && !pop) begin
            s_nxt.count = s_r.count + 2'h1;
        end else if (pop && !push) begin
            s_nxt.count = s_r.count - 2'h1;
        end
    end

    // state register
    always_ff @(posedge mclk) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // no entry is lost or invented
    buf_no_overflow_a: assert property (s_r.count <= BUF_DEPTH)
        else $error("buffer count above depth");
    buf_order_a: assert property (push && !outValid |=> outData == $past(inData))
        else $error("buffer lost first byte");
    buf_full_c: cover property (s_r.count == BUF_DEPTH);
endmodule : bpf_byte_buf
`default_nettype wire

/* File: core/bpf_framer.sv */
// packet framer: turns one set of readings into a serial packet
// assumes readings are offered with a valid/ready handshake on mclk
// assumes the bit time is set by BIT_TIME, in cycles of mclk
`timescale 1ns/1ps
`default_nettype none
module bpf_framer #(
    // cycles per serial bit; a bench may shorten it to keep runs brief,
    // hardware keeps the package value for the line's real baud rate
    parameter logic [10:0] BIT_TIME = bpf_pkg::BIT_CYCLES
) (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        recValid,
    output logic             recReady,
    input  wire logic [7:0]  recQuality,
    input  wire logic [7:0]  recHeartRate,
    input  wire logic [15:0] recRaw,
    output logic             txd,
    output logic             busy
);
    import bpf_pkg::*;

    localparam bpf_frm_state_t RST_STATE = '{
        phase: PH_IDLE, txd: 1'b1, default: '0};

    bpf_frm_state_t s_r;
    bpf_frm_state_t s_nxt;
    logic [7:0]     curByte;
    logic           bufInValid;
    logic           bufInReady;
    logic           bufOutValid;
    logic           bufOutReady;
    logic [7:0]     bufOutData;
    logic           push;
    logic           pop;
    logic           inPayload;

    // byte at the current packet position
    always_comb begin
        case (s_r.idx)
            IDX_SYNC0: curByte = SYNC_BYTE;
            IDX_SYNC1: curByte = SYNC_BYTE;
            IDX_LEN:   curByte = PAYLOAD_BYTE_COUNT;
            IDX_QCODE: curByte = CODE_QUALITY;
            IDX_QDATA: curByte = s_r.quality;
            IDX_HCODE: curByte = CODE_HEART;
            IDX_HDATA: curByte = s_r.heart;
            IDX_RCODE: curByte = CODE_RAW;
            IDX_RLEN:  curByte = RAW_LEN;
            IDX_RHI:   curByte = s_r.raw[15:8];
            IDX_RLO:   curByte = s_r.raw[7:0];
            IDX_CKSUM: curByte = ~s_r.sum;
            default:   curByte = 8'h00;
        endcase
    end

    // records at level 0 follow each other with no prefix bytes
    assign inPayload  = (s_r.idx >= IDX_QCODE) && (s_r.idx <= IDX_RLO);
    // the packer offers a byte every cycle while a packet is open
    assign bufInValid = (s_r.phase == PH_SEND);
    assign push       = bufInValid && bufInReady;
    assign bufOutReady = !s_r.txBusy;
    assign pop        = bufOutValid && bufOutReady;
    // new readings wait until the checksum has left the packer; the old
    // packet may still be draining through the buffer and serialiser
    assign recReady   = (s_r.phase == PH_IDLE);
    assign txd        = s_r.txd;
    assign busy       = (s_r.phase == PH_SEND) || s_r.txBusy || bufOutValid;

    // byte path to the serialiser; a stalled serialiser stalls the packer
    bpf_byte_buf u_buf (
        .mclk     (mclk),
        .rst      (rst),
        .inValid  (bufInValid),
        .inReady  (bufInReady),
        .inData   (curByte),
        .outValid (bufOutValid),
        .outReady (bufOutReady),
        .outData  (bufOutData)
    );

    // next state: packet sequencer and serialiser
    always_comb begin
        s_nxt = s_r;
        // take a new set of readings only between packets
        if (recValid && recReady) begin
            s_nxt.phase   = PH_SEND;
            s_nxt.idx     = IDX_SYNC0;
            s_nxt.sum     = 8'h00;
            s_nxt.quality = recQuality;
            s_nxt.heart   = recHeartRate;
            s_nxt.raw     = recRaw;
        end
        // walk header, payload, checksum in order
        if (push) begin
            if (inPayload) begin
                s_nxt.sum = s_r.sum + curByte;
            end
            if (s_r.idx == IDX_CKSUM) begin
                s_nxt.phase = PH_IDLE;
            end else begin
                s_nxt.idx = s_r.idx + 4'h1;
            end
        end
        // serial frame: start bit low, lsb first, stop bit high
        // the stop bit stands one cycle longer than the others, since the
        // next byte is only popped once the busy flag has cleared
        if (pop) begin
            s_nxt.txBusy  = 1'b1;
            s_nxt.shift   = {1'b1, bufOutData, 1'b0};
            s_nxt.bitCnt  = 4'h0;
            s_nxt.baudCnt = 11'h000;
            s_nxt.txd     = 1'b0;
        end else if (s_r.txBusy) begin
            if (s_r.baudCnt == BIT_TIME - 11'h001) begin
                s_nxt.baudCnt = 11'h000;
                if (s_r.bitCnt == LAST_BIT) begin
                    s_nxt.txBusy = 1'b0;
                    s_nxt.txd    = 1'b1;
                end else begin
                    s_nxt.bitCnt = s_r.bitCnt + 4'h1;
                    s_nxt.shift  = {1'b1, s_r.shift[9:1]};
                    s_nxt.txd    = s_r.shift[1];
                end
            end else begin
                s_nxt.baudCnt = s_r.baudCnt + 11'h001;
            end
        end
    end

    // state register
    always_ff @(posedge mclk) begin
        if (rst) begin
            s_r <= RST_STATE;
        end else begin
            s_r <= s_nxt;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // header bytes
    sync_marker_a: assert property (
        push && (s_r.idx <= IDX_SYNC1) |-> curByte == SYNC_BYTE)
        else $error("frame marker byte wrong");
    length_byte_a: assert property (
        push && s_r.idx == IDX_LEN |=> s_r.idx == IDX_QCODE
            && $past(curByte) == PAYLOAD_BYTE_COUNT)
        else $error("payload length byte wrong");
    // checksum covers exactly the payload bytes, rebuilt from the readings
    checksum_value_a: assert property (
        push && s_r.idx == IDX_CKSUM |-> curByte == ~(8'(CODE_QUALITY
            + s_r.quality + CODE_HEART + s_r.heart + CODE_RAW + RAW_LEN
            + s_r.raw[15:8] + s_r.raw[7:0])))
        else $error("checksum byte wrong");
    packet_order_a: assert property (
        push && s_r.idx == IDX_CKSUM |=> s_r.phase == PH_IDLE)
        else $error("packet did not end after checksum");
    code_not_marker_a: assert property (
        push && (s_r.idx == IDX_QCODE || s_r.idx == IDX_HCODE
            || s_r.idx == IDX_RCODE) |-> curByte != EXTENSION_PREFIX_BYTE
            && curByte != SYNC_BYTE)
        else $error("code byte looks like marker or prefix");
    short_record_a: assert property (
        push && s_r.idx == IDX_HCODE |-> curByte < LONG_CODE_MIN
            && s_r.idx + 4'h2 == IDX_RCODE)
        else $error("short record layout wrong");
    quality_code_a: assert property (
        push && s_r.idx == IDX_QDATA |-> $past(s_r.idx) == IDX_QCODE
            || $past(s_r.idx) == IDX_QDATA)
        else $error("quality data not after its code");
    heart_code_a: assert property (
        push && s_r.idx == IDX_HCODE |-> curByte == CODE_HEART)
        else $error("heart rate code wrong");
    raw_record_a: assert property (
        push && s_r.idx == IDX_RCODE |=> $past(curByte) == CODE_RAW
            && s_r.idx == IDX_RLEN && curByte == RAW_LEN)
        else $error("raw record code or length wrong");
    start_bit_a: assert property (
        pop |=> !txd [*8])
        else $error("start bit not held low");
    stop_bit_a: assert property (
        s_r.txBusy && s_r.bitCnt == LAST_BIT |-> txd)
        else $error("stop bit not high");
    // serial line idles high and every bit but the stop bit lasts one bit time
    idle_line_a: assert property (!s_r.txBusy |-> txd)
        else $error("line not idle high between bytes");
    bit_timer_a: assert property (s_r.baudCnt < BIT_TIME)
        else $error("bit timer past one bit time");
    lsb_first_a: assert property (
        pop |=> s_r.shift[8:1] == $past(bufOutData) && !s_r.shift[0]
            && s_r.shift[9])
        else $error("frame not loaded start, data, stop");
    // readings are held from the take to the checksum
    readings_taken_a: assert property (
        recValid && recReady |=> !recReady && busy
            && s_r.quality == $past(recQuality)
            && s_r.heart == $past(recHeartRate) && s_r.raw == $past(recRaw))
        else $error("readings not taken as offered");
    quality_record_a: assert property (
        push && s_r.idx == IDX_QCODE |-> curByte == CODE_QUALITY
            && curByte < LONG_CODE_MIN)
        else $error("quality code wrong");
    data_bytes_a: assert property (
        push && (s_r.idx == IDX_QDATA || s_r.idx == IDX_HDATA) |-> curByte
            == (s_r.idx == IDX_QDATA ? s_r.quality : s_r.heart))
        else $error("short record data byte wrong");
    packet_len_a: assert property (
        push && s_r.idx == IDX_LEN |-> curByte == 8'(IDX_CKSUM - IDX_QCODE))
        else $error("length byte does not match payload positions");
    // packer only runs while a packet is open, and holds while stalled
    packer_idle_a: assert property (s_r.phase == PH_IDLE |-> !push)
        else $error("byte pushed outside a packet");
    busy_drain_a: assert property (s_r.txBusy |-> busy)
        else $error("busy low while a byte is on the line");
    sum_reset_a: assert property (
        push && s_r.idx == IDX_QCODE |-> s_r.sum == 8'h00)
        else $error("running sum not cleared at payload start");
    stall_hold_a: assert property (
        bufInValid && !bufInReady |=> s_r.idx == $past(s_r.idx))
        else $error("packet position moved during a stall");

    // main scenarios: full packet, stall, back to back
    packet_done_c: cover property (push && s_r.idx == IDX_CKSUM);
    stall_c: cover property (bufInValid && !bufInReady);
    back_to_back_c: cover property (
        push && s_r.idx == IDX_CKSUM ##[1:5] recValid && recReady);
endmodule : bpf_framer
`default_nettype wire

/* File: testbench/bpf_host_rx.sv */
// host-side serial receiver model: turns txd into bytes
// assumes txd idles high and bit time is BIT_TIME cycles of mclk
`timescale 1ns/1ps
`default_nettype none
module bpf_host_rx
    import bpf_pkg::*;
#(
    parameter logic [10:0] BIT_TIME = BIT_CYCLES
) (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       txd,
    output logic            byteStrobe,
    output logic [7:0]      byteData,
    output logic            stopBit
);
    // sample mid-bit on falling edges, clear of txd updates
    initial begin
        byteStrobe = 1'b0;
        byteData   = 8'h00;
        stopBit    = 1'b1;
        forever begin
            @(negedge mclk);
            if (!rst && txd === 1'b0) begin
                repeat (int'(BIT_TIME) / 2) @(negedge mclk);
                for (int i = 0; i < 8; i++) begin // lsb first
                    repeat (int'(BIT_TIME)) @(negedge mclk);
                    byteData[i] = txd;
                end
                repeat (int'(BIT_TIME)) @(negedge mclk);
                stopBit    = txd;
                byteStrobe = 1'b1;
                @(negedge mclk);
                byteStrobe = 1'b0;
            end
        end
    end
endmodule : bpf_host_rx
`default_nettype wire

/* File: testbench/tb.sv */
// testbench for the packet framer: sends readings, decodes the line
// assumes one 100 MHz clock; a short bit time keeps a packet near 2k cycles
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin \
    num_errors++; $display("unexpected at %0t: got %h want %h", \
    $time, g, e); end end
module tb;
    import bpf_pkg::*;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        recValid = 1'b0;
    logic [7:0]  recQuality = 8'h00;
    logic [7:0]  recHeartRate = 8'h00;
    logic [15:0] recRaw = 16'h0000;
    logic        recReady, txd, busy, byteStrobe, stopBit;
    logic [7:0]  byteData;
    logic [7:0]  rxq[$];
    int          num_errors = 0;
    int          comparisons = 0;
    int          cyc = 0;
    localparam logic [10:0] TB_BIT_TIME = 11'h010;
    localparam int          WAIT_LIMIT  = 5000;

    bpf_framer #(.BIT_TIME(TB_BIT_TIME)) i_bpf_framer (.mclk(mclk),
        .rst(rst), .recValid(recValid),
        .recReady(recReady), .recQuality(recQuality),
        .recHeartRate(recHeartRate), .recRaw(recRaw), .txd(txd),
        .busy(busy));
    bpf_host_rx #(.BIT_TIME(TB_BIT_TIME)) i_bpf_host_rx (.mclk(mclk),
        .rst(rst), .txd(txd),
        .byteStrobe(byteStrobe), .byteData(byteData), .stopBit(stopBit));

    // clock, byte collection and hang guard
    always #5 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc++;
        if (byteStrobe) begin
            rxq.push_back(byteData);
            `CHK(stopBit, 1'b1)
        end
        if (cyc == 20000) begin
            num_errors++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("checks %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : complete_run

    // host-side parse of one captured stream; records only after checksum
    function automatic logic decode_pkt(input logic [7:0] b[16],
                                        output logic [7:0] q,
                                        output logic [7:0] h,
                                        output logic [15:0] r);
        int p;
        int len;
        int lim;
        int lvl;
        int dlen;
        logic [7:0] s;
        logic [7:0] code;
        p = 0;
        s = 8'h00;
        q = 8'h00;
        h = 8'h00;
        r = 16'h0000;
        while (p < 14 && !(b[p] == SYNC_BYTE && b[p + 1] == SYNC_BYTE))
            p++;
        if (p >= 14) return 1'b0;
        len = int'(b[p + 2]);
        p = p + 3;
        lim = p + len;
        if (lim > 15) return 1'b0;
        for (int i = p; i < lim; i++) s = s + b[i];
        if (b[lim] != ~s) return 1'b0; // drop, report no packet
        // records are read only once the checksum matched
        while (p < lim) begin
            lvl = 0;
            while (p < lim && b[p] == EXTENSION_PREFIX_BYTE) begin
                lvl++;
                p++;
            end
            code = (p < lim) ? b[p] : 8'h00;
            p++;
            dlen = 1;
            if (code >= LONG_CODE_MIN) begin
                dlen = (p < lim) ? int'(b[p]) : 0;
                p++;
            end
            if (p + dlen > lim) begin // overrun drops the rest
                p = lim;
            end else begin
                // type from level and code, others skipped whole
                if (lvl == 0 && code == CODE_QUALITY) q = b[p];
                if (lvl == 0 && code == CODE_HEART) h = b[p];
                if (lvl == 0 && code == CODE_RAW && dlen == 2)
                    r = {b[p], b[p + 1]};
                p = p + dlen;
            end
        end
        return 1'b1;
    endfunction : decode_pkt

    // offer readings and hold them until taken
    task automatic offer(input logic [7:0] q, input logic [7:0] h,
                         input logic [15:0] r);
        int n;
        n = 0;
        @(posedge mclk);
        recValid     <= 1'b1;
        recQuality   <= q;
        recHeartRate <= h;
        recRaw       <= r;
        @(negedge mclk);
        while (!recReady && n < WAIT_LIMIT) begin
            @(negedge mclk);
            n++;
        end
        @(posedge mclk);
        recValid <= 1'b0;
        recQuality <= ~q; // taken value must not follow the inputs
        @(negedge mclk);
        `CHK(recReady, 1'b0)
        `CHK(busy, 1'b1)
    endtask : offer

    // wait for one packet and compare it with the expected bytes
    task automatic check_pkt(input logic [7:0] q, input logic [7:0] h,
                             input logic [15:0] r);
        logic [7:0] exp[12];
        logic [7:0] got[16];
        logic [7:0] alt[16];
        logic [7:0] s;
        logic [7:0] dq;
        logic [7:0] dh;
        logic [15:0] dr;
        logic ok;
        int n;
        n = 0;
        exp = '{8'haa, 8'haa, 8'h08, 8'h02, q, 8'h03, h, 8'h80, 8'h02,
                r[15:8], r[7:0], 8'h00};
        s = 8'h00;
        for (int i = 3; i < 11; i++) s = s + exp[i];
        exp[11] = ~s;
        for (int i = 0; i < 16; i++) got[i] = 8'h00;
        while (rxq.size() < 12 && n < WAIT_LIMIT) begin
            @(posedge mclk);
            n++;
        end
        for (int i = 0; i < 12 && rxq.size() > 0; i++)
            got[i] = rxq.pop_front();
        for (int i = 0; i < 12; i++)
            `CHK(got[i], exp[i])
        `CHK(n < WAIT_LIMIT, 1'b1)
        // host parse of the packet as sent
        ok = decode_pkt(got, dq, dh, dr);
        `CHK(ok, 1'b1)
        `CHK(dq, q)
        `CHK(dh, h)
        `CHK(dr, r)
        // a lone marker before the packet restarts the hunt
        alt[0] = SYNC_BYTE;
        alt[1] = 8'h00;
        for (int i = 2; i < 16; i++) alt[i] = got[i - 2];
        ok = decode_pkt(alt, dq, dh, dr);
        `CHK(ok, 1'b1)
        `CHK(dh, h)
        // a bad checksum throws the whole packet away
        alt = got;
        alt[11] = ~got[11];
        ok = decode_pkt(alt, dq, dh, dr);
        `CHK(ok, 1'b0)
        // level-one code and unknown long record are skipped
        alt = '{8'haa, 8'haa, 8'h06, 8'h55, 8'h03, 8'h09, 8'h85, 8'h01,
                8'h33, 8'he5, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        ok = decode_pkt(alt, dq, dh, dr);
        `CHK(ok, 1'b1)
        `CHK(dh, 8'h00)
        // a record running past the payload ends the parse there
        alt = '{8'haa, 8'haa, 8'h04, 8'h03, 8'h21, 8'h85, 8'h05, 8'h51,
                8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        ok = decode_pkt(alt, dq, dh, dr);
        `CHK(ok, 1'b1)
        `CHK(dh, 8'h21)
        $display("packet %h %h %h done", q, h, r);
    endtask : check_pkt

    task automatic test_reset();
        `CHK(txd, 1'b1)
        `CHK(recReady, 1'b1)
        `CHK(busy, 1'b0)
        $display("reset test done");
    endtask : test_reset

    // second request held while the first packet is still going
    task automatic test_back_to_back();
        offer(8'hc8, 8'h48, 16'h8001); // quality on
        repeat (20) @(negedge mclk);
        `CHK(recReady, 1'b0)
        offer(8'h00, 8'hff, 16'h7fff); // sum wraps
        check_pkt(8'hc8, 8'h48, 16'h8001);
        check_pkt(8'h00, 8'hff, 16'h7fff);
        repeat (400) @(negedge mclk);
        `CHK(busy, 1'b0)
        `CHK(txd, 1'b1)
        `CHK(rxq.size(), 0)
        $display("back to back test done");
    endtask : test_back_to_back

    // reset for 10 cycles, then the scenarios
    initial begin
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        @(negedge mclk);
        test_reset();
        test_back_to_back();
        complete_run();
    end
endmodule : tb
`default_nettype wire
